/* File: src/leci_defines.svh */
// Register offsets, widths and error run lengths for the line error counter
`ifndef LECI_DEFINES_SVH
`define LECI_DEFINES_SVH

`define LECI_ADDR_COUNT_HIGH 8'h11
`define LECI_ADDR_COUNT_LOW  8'h12
`define LECI_ADDR_WIDTH      8
`define LECI_DATA_WIDTH      8
`define LECI_COUNT_WIDTH     16
`define LECI_COUNT_MAX       16'hFFFF
`define LECI_COUNT_RESET     16'h0000
`define LECI_ZERO_WIDTH      5
`define LECI_ZERO_MAX        5'h1F
`define LECI_E1_EXZ_RUN      5'h04
`define LECI_B8ZS_EXZ_RUN    5'h08
`define LECI_AMI_EXZ_RUN     5'h10
`define LECI_B8ZS_V1_ZEROS   5'h03
`define LECI_B8ZS_V2_ZEROS   5'h01
`define LECI_HDB3_MIN_ZEROS  5'h02
`define LECI_INS_ONES        2'h3

`endif

/* File: src/leci_line_check.sv */
// Receive line code checker: bipolar violations, code violations, zero runs
`timescale 1ns/1ps
`include "leci_defines.svh"

module leci_line_check (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     rx_pos,
  input  wire logic                     rx_neg,
  input  wire logic                     t1_mode,
  input  wire logic                     coding_off,
  output leci_pkg::leci_rx_err_type     err
);
  logic                              last_pol;
  logic                              next_last_pol;
  logic                              last_v_pol;
  logic                              next_last_v_pol;
  logic [`LECI_ZERO_WIDTH-1:0]       zeros;
  logic [`LECI_ZERO_WIDTH-1:0]       next_zeros;
  leci_pkg::leci_b8zs_state_type     stage;
  leci_pkg::leci_b8zs_state_type     next_stage;
  leci_pkg::leci_rx_err_type         next_err;
  logic                              mark;
  logic                              pol;
  logic                              viol;
  logic                              exempt;

  always_comb begin
    mark            = rx_pos | rx_neg;
    pol             = rx_neg & ~rx_pos;
    viol            = mark && (pol == last_pol);
    exempt          = 1'b0;
    next_stage      = leci_pkg::B8_IDLE;
    next_last_pol   = mark ? pol : last_pol;
    next_last_v_pol = viol ? pol : last_v_pol;
    next_zeros      = mark ? '0 :
                      (zeros == `LECI_ZERO_MAX) ? zeros : zeros + `LECI_ZERO_WIDTH'(1);
    if (t1_mode && !coding_off) begin
      case (stage)
        leci_pkg::B8_IDLE: begin
          if (viol && zeros == `LECI_B8ZS_V1_ZEROS) next_stage = leci_pkg::B8_AFTER_V;
        end
        leci_pkg::B8_AFTER_V: begin
          if (mark && !viol) next_stage = leci_pkg::B8_AFTER_B;
        end
        leci_pkg::B8_AFTER_B: begin
          if (!mark) next_stage = leci_pkg::B8_AFTER_ZERO;
        end
        default: next_stage = leci_pkg::B8_IDLE;
      endcase
    end
    if (!coding_off) begin
      if (!t1_mode) begin
        exempt = viol && (zeros >= `LECI_HDB3_MIN_ZEROS);
      end else begin
        exempt = viol && ((stage == leci_pkg::B8_IDLE && zeros == `LECI_B8ZS_V1_ZEROS) ||
                          (stage == leci_pkg::B8_AFTER_ZERO && zeros == `LECI_B8ZS_V2_ZEROS));
      end
    end
    next_err.bpv = viol && !exempt;
    next_err.cv  = !t1_mode && !coding_off && viol && (pol == last_v_pol);
    if (!t1_mode) begin
      next_err.exz = next_zeros == `LECI_E1_EXZ_RUN;
    end else if (coding_off) begin
      next_err.exz = (next_zeros == `LECI_AMI_EXZ_RUN) || next_err.bpv;
    end else begin
      next_err.exz = (next_zeros == `LECI_B8ZS_EXZ_RUN) || next_err.bpv;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      last_pol   <= 1'b1;
      last_v_pol <= 1'b1;
      zeros      <= '0;
      stage      <= leci_pkg::B8_IDLE;
      err        <= '0;
    end else begin
      last_pol   <= next_last_pol;
      last_v_pol <= next_last_v_pol;
      zeros      <= next_zeros;
      stage      <= next_stage;
      err        <= next_err;
    end
  end

endmodule : leci_line_check

/* File: src/leci_pkg.sv */
// Types shared by the line error counter and injector
package leci_pkg;

  typedef struct packed {
    logic bpv;
    logic cv;
    logic exz;
  } leci_rx_err_type;

  typedef struct packed {
    logic t1_mode;
    logic coding_off;
    logic sel_prbs;
    logic sel_bit1;
    logic sel_bit0;
  } leci_sel_type;

  typedef enum logic [1:0] {
    B8_IDLE,
    B8_AFTER_V,
    B8_AFTER_B,
    B8_AFTER_ZERO
  } leci_b8zs_state_type;

  typedef enum logic {
    INS_IDLE,
    INS_ARMED
  } leci_ins_state_type;

endpackage : leci_pkg

/* File: src/leci_top.sv */
// Line error counter, error selector and transmit error injector
`timescale 1ns/1ps
`include "leci_defines.svh"

// Functional notes
// - Sixteen bit count read as two bytes
// - Same polarity marks flagged, codewords exempt
// - E1 HDB3: repeated violation polarity flagged
// - E1: four zeros flag excess zeros
// - T1 AMI: sixteen zeros or violation
// - T1 B8ZS: eight zeros or violation
// - E1 select bits choose counted errors
// - T1 select bit zero adds excess zeros
// - PRBS select counts only PRBS errors
// - PRBS errors only on PRBS output
// - NRZ mode pulses errors on negative pin
// - Trigger rise latches and clears counter
// - Counter saturates at maximum
// - Violation inserted on the third successive one
// - Insert bit rise flips one bit
// - Synchronized PRBS errors pulse output
module leci_top #(
  parameter int COUNT_WIDTH = `LECI_COUNT_WIDTH
) (
  input  wire logic                          CLK,
  input  wire logic                          SRST,
  input  wire logic                          RX_POS,
  input  wire logic                          RX_NEG,
  input  wire logic                          LINE_STANDARD_SELECT,
  input  wire logic                          RX_ZERO_SUB_CODING_OFF,
  input  wire logic                          NRZ_MODE,
  input  wire logic                          COUNT_SELECT_PRBS,
  input  wire logic                          COUNT_SELECT_BIT1,
  input  wire logic                          COUNT_SELECT_BIT0,
  input  wire logic                          COUNTER_UPDATE_TRIGGER,
  input  wire logic                          PRBS_IN_SYNC,
  input  wire logic                          PRBS_BIT_ERROR,
  input  wire logic [`LECI_ADDR_WIDTH-1:0]   REG_ADDR,
  output logic      [`LECI_DATA_WIDTH-1:0]   REG_RDATA,
  output logic                               RX_POS_DATA_OUT,
  output logic                               RX_NEGATIVE_DATA_PIN,
  output logic                               PRBS_ERROR_PULSE_OUT,
  input  wire logic                          INSERT_BIPOLAR_VIOLATION,
  input  wire logic                          INSERT_LOGIC_ERROR,
  input  wire logic                          TX_POS_IN,
  input  wire logic                          TX_NEG_IN,
  output logic                               TX_POS_OUT,
  output logic                               TX_NEG_OUT
);
  leci_pkg::leci_rx_err_type   line_err;
  leci_pkg::leci_sel_type      sel;
  logic [COUNT_WIDTH-1:0]      running;
  logic [COUNT_WIDTH-1:0]      next_running;
  logic [COUNT_WIDTH-1:0]      latched;
  logic [COUNT_WIDTH-1:0]      next_latched;
  logic [`LECI_DATA_WIDTH-1:0] next_rdata;
  logic                        trig_prev;
  logic                        trig_rise;
  logic                        prbs_err;
  logic                        next_prbs_err;
  logic                        counted;
  logic                        line_pulse;
  logic                        next_pos_out;
  logic                        next_neg_out;

  // Checker sees the same bit stream the counter counts
  leci_line_check u_check (
    .clk        (CLK),
    .srst       (SRST),
    .rx_pos     (RX_POS),
    .rx_neg     (RX_NEG),
    .t1_mode    (LINE_STANDARD_SELECT),
    .coding_off (RX_ZERO_SUB_CODING_OFF),
    .err        (line_err)
  );

  // Selected line error, PRBS excluded so it never reaches the pin
  function automatic logic pick_line_err(leci_pkg::leci_sel_type s,
                                         leci_pkg::leci_rx_err_type e);
    logic r;
    r = 1'b0;
    if (!s.t1_mode) begin
      case ({s.sel_bit1, s.sel_bit0})
        2'b00:   r = e.cv;
        2'b01:   r = e.bpv;
        2'b10:   r = e.cv | e.exz;
        default: r = e.bpv | e.exz;
      endcase
    end else begin
      r = s.sel_bit0 ? e.exz : e.bpv;
    end
    return r;
  endfunction : pick_line_err

  always_comb begin
    sel.t1_mode    = LINE_STANDARD_SELECT;
    sel.coding_off = RX_ZERO_SUB_CODING_OFF;
    sel.sel_prbs   = COUNT_SELECT_PRBS;
    sel.sel_bit1   = COUNT_SELECT_BIT1;
    sel.sel_bit0   = COUNT_SELECT_BIT0;
    line_pulse     = pick_line_err(sel, line_err);
    counted        = sel.sel_prbs ? prbs_err : line_pulse;
    trig_rise      = COUNTER_UPDATE_TRIGGER && !trig_prev;
    // errors count only once in sync
    next_prbs_err  = PRBS_BIT_ERROR && PRBS_IN_SYNC;
    next_latched   = trig_rise ? running : latched;
    if (trig_rise) begin
      next_running = counted ? COUNT_WIDTH'(1) : '0;
    end else if (counted && running != {COUNT_WIDTH{1'b1}}) begin
      next_running = running + COUNT_WIDTH'(1);
    end else begin
      next_running = running;
    end
    case (REG_ADDR)
      `LECI_ADDR_COUNT_HIGH: next_rdata = latched[COUNT_WIDTH-1 -: `LECI_DATA_WIDTH];
      `LECI_ADDR_COUNT_LOW:  next_rdata = latched[`LECI_DATA_WIDTH-1:0];
      default:               next_rdata = '0;
    endcase
    next_pos_out   = NRZ_MODE ? (RX_POS | RX_NEG) : RX_POS;
    next_neg_out   = NRZ_MODE ? line_pulse : RX_NEG;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      trig_prev            <= 1'b0;
      running              <= '0;
      latched              <= '0;
      prbs_err             <= 1'b0;
      REG_RDATA            <= '0;
      RX_POS_DATA_OUT      <= 1'b0;
      RX_NEGATIVE_DATA_PIN <= 1'b0;
    end else begin
      trig_prev            <= COUNTER_UPDATE_TRIGGER;
      running              <= next_running;
      latched              <= next_latched;
      prbs_err             <= next_prbs_err;
      REG_RDATA            <= next_rdata;
      RX_POS_DATA_OUT      <= next_pos_out;
      RX_NEGATIVE_DATA_PIN <= next_neg_out;
    end
  end

  assign PRBS_ERROR_PULSE_OUT = prbs_err;

  // Transmit injector
  leci_pkg::leci_ins_state_type ins_state;
  leci_pkg::leci_ins_state_type next_ins_state;
  logic [1:0] ones;
  logic [1:0] next_ones;
  logic       bpv_prev;
  logic       be_prev;
  logic       be_pend;
  logic       next_be_pend;
  logic       tx_last_pol;
  logic       next_tx_last_pol;
  logic       tx_mark;
  logic       do_bpv;
  logic       do_be;
  logic       out_pos;
  logic       out_neg;

  always_comb begin
    tx_mark        = TX_POS_IN | TX_NEG_IN;
    next_ins_state = ins_state;
    next_ones      = tx_mark ? ones : 2'd0;
    do_bpv         = 1'b0;
    // arm on rise, fire on third one
    case (ins_state)
      leci_pkg::INS_IDLE: begin
        if (INSERT_BIPOLAR_VIOLATION && !bpv_prev) begin
          next_ins_state = leci_pkg::INS_ARMED;
          next_ones      = 2'd0;
        end
      end
      leci_pkg::INS_ARMED: begin
        if (tx_mark) begin
          next_ones = ones + 2'd1;
          if (ones == `LECI_INS_ONES - 2'd1) begin
            do_bpv         = 1'b1;
            next_ins_state = leci_pkg::INS_IDLE;
            next_ones      = 2'd0;
          end
        end
      end
      default: next_ins_state = leci_pkg::INS_IDLE;
    endcase
    // flip the next bit after the rise
    do_be        = be_pend || (INSERT_LOGIC_ERROR && !be_prev);
    do_be        = do_be && !do_bpv;
    next_be_pend = do_be ? 1'b0 : (be_pend || (INSERT_LOGIC_ERROR && !be_prev));
    if (do_bpv) begin
      out_pos = !tx_last_pol;
      out_neg = tx_last_pol;
    end else if (do_be) begin
      // Space becomes a legal mark so only one fault appears
      out_pos = !tx_mark && tx_last_pol;
      out_neg = !tx_mark && !tx_last_pol;
    end else begin
      out_pos = TX_POS_IN;
      out_neg = TX_NEG_IN;
    end
    next_tx_last_pol = (out_pos | out_neg) ? out_neg : tx_last_pol;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ins_state   <= leci_pkg::INS_IDLE;
      ones        <= 2'd0;
      bpv_prev    <= 1'b0;
      be_prev     <= 1'b0;
      be_pend     <= 1'b0;
      tx_last_pol <= 1'b1;
      TX_POS_OUT  <= 1'b0;
      TX_NEG_OUT  <= 1'b0;
    end else begin
      ins_state   <= next_ins_state;
      ones        <= next_ones;
      bpv_prev    <= INSERT_BIPOLAR_VIOLATION;
      be_prev     <= INSERT_LOGIC_ERROR;
      be_pend     <= next_be_pend;
      tx_last_pol <= next_tx_last_pol;
      TX_POS_OUT  <= out_pos;
      TX_NEG_OUT  <= out_neg;
    end
  end

  // Checks
  sequence s_trig_rise;
    !COUNTER_UPDATE_TRIGGER ##1 COUNTER_UPDATE_TRIGGER;
  endsequence

  chk_latch_copy: assert property (@(posedge CLK) disable iff (SRST)
    s_trig_rise |=> (latched == $past(running)))
    else $error("latched count not copied on trigger rise");

  chk_latch_clear: assert property (@(posedge CLK) disable iff (SRST)
    s_trig_rise |=> (running <= COUNT_WIDTH'(1)))
    else $error("running count not cleared on trigger rise");

  chk_hold_high: assert property (@(posedge CLK) disable iff (SRST)
    COUNTER_UPDATE_TRIGGER && trig_prev |=> $stable(latched))
    else $error("latched count changed without fresh rise");

  chk_count_sat: assert property (@(posedge CLK) disable iff (SRST)
    (running == {COUNT_WIDTH{1'b1}}) && !trig_rise |=> (running == {COUNT_WIDTH{1'b1}}))
    else $error("counter wrapped past maximum");

  chk_count_step: assert property (@(posedge CLK) disable iff (SRST)
    !trig_rise |=> (running - $past(running) <= COUNT_WIDTH'(1)))
    else $error("counter advanced more than one");

  chk_prbs_only: assert property (@(posedge CLK) disable iff (SRST)
    COUNT_SELECT_PRBS && !prbs_err && !trig_rise |=> $stable(running))
    else $error("line error counted while PRBS selected");

  chk_prbs_pulse: assert property (@(posedge CLK) disable iff (SRST)
    PRBS_BIT_ERROR && PRBS_IN_SYNC |=> PRBS_ERROR_PULSE_OUT)
    else $error("PRBS error not pulsed");

  chk_neg_pin: assert property (@(posedge CLK) disable iff (SRST)
    NRZ_MODE && !line_pulse |=> !RX_NEGATIVE_DATA_PIN)
    else $error("negative pin pulsed without error in NRZ mode");

  chk_read_high: assert property (@(posedge CLK) disable iff (SRST)
    REG_ADDR == `LECI_ADDR_COUNT_HIGH |=>
      REG_RDATA == $past(latched[COUNT_WIDTH-1 -: `LECI_DATA_WIDTH]))
    else $error("high byte read wrong");

  chk_bpv_once: assert property (@(posedge CLK) disable iff (SRST)
    do_bpv |=> (ins_state == leci_pkg::INS_IDLE) [*2])
    else $error("violation insert rearmed without fresh rise");

  chk_be_flip: assert property (@(posedge CLK) disable iff (SRST)
    do_be |=> ((TX_POS_OUT | TX_NEG_OUT) != $past(tx_mark)))
    else $error("logic error not inserted");

endmodule : leci_top

/* File: test/leci_line_model.sv */
// Line side model: received mark stream and transmit stream monitor
`timescale 1ns/1ps
module leci_line_model (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic tx_pos_in,
  input  wire logic tx_neg_in,
  input  wire logic tx_pos,
  input  wire logic tx_neg,
  output logic      rx_pos,
  output logic      rx_neg
);
  logic rx_last_pos;
  logic tx_last_pos;
  logic d_pos;
  logic d_neg;
  int   tx_viols;
  int   tx_diffs;

  initial begin
    {rx_pos, rx_neg} = 2'h0;
    rx_last_pos = 1'b0;
  end

  // M alternates polarity, V repeats the last one, 0 is a space
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      #1;
      if (s[i] == "0") begin
        {rx_pos, rx_neg} = 2'h0;
      end else begin
        if (s[i] == "M") begin
          rx_last_pos = !rx_last_pos;
        end
        {rx_pos, rx_neg} = rx_last_pos ? 2'h2 : 2'h1;
      end
    end
  endtask : send_str

  // Output compared with input one bit later; any difference is an injected error
  always @(posedge clk) begin
    if (srst) begin
      rx_last_pos <= 1'b0;
      tx_last_pos <= 1'b0;
      tx_viols    <= 0;
      tx_diffs    <= 0;
    end else begin
      if ({tx_pos, tx_neg} !== {d_pos, d_neg}) begin
        tx_diffs <= tx_diffs + 1;
      end
      if (tx_pos || tx_neg) begin
        tx_last_pos <= tx_pos;
        if (tx_pos == tx_last_pos) begin
          tx_viols <= tx_viols + 1;
        end
      end
    end
    d_pos <= tx_pos_in;
    d_neg <= tx_neg_in;
  end
endmodule : leci_line_model

/* File: test/leci_top_test.sv */
// Self-checking bench for the line error counter and injector
`timescale 1ns/1ps
module leci_top_test;
  localparam string PA = "MMMV00000MMV00";
  localparam string PB = "M0000000000MV00";
  logic       clk;
  logic       srst;
  logic       rx_pos;
  logic       rx_neg;
  logic       lstd;
  logic       coff;
  logic [2:0] sel;
  logic       trig;
  logic       psync;
  logic       perr;
  logic [7:0] addr;
  logic [7:0] rdata;
  logic       rx_negative_data_pin_out;
  logic       rpos_out;
  logic       nrz;
  int         n_pos;
  logic       prbs_error_pulse_out;
  logic       insert_bipolar_violation;
  logic       insert_logic_error;
  logic       txp_in;
  logic       txn_in;
  logic       txp_out;
  logic       txn_out;
  logic       tx_last;
  logic       mon_en;
  logic [15:0] v;
  logic [7:0] b;
  int         n_mismatch;
  int         comparisons;
  int         n_neg;
  int         n_prbs;

  leci_top dut (
    .CLK(clk), .SRST(srst), .RX_POS(rx_pos), .RX_NEG(rx_neg),
    .LINE_STANDARD_SELECT(lstd), .RX_ZERO_SUB_CODING_OFF(coff), .NRZ_MODE(nrz),
    .COUNT_SELECT_PRBS(sel[2]), .COUNT_SELECT_BIT1(sel[1]), .COUNT_SELECT_BIT0(sel[0]),
    .COUNTER_UPDATE_TRIGGER(trig), .PRBS_IN_SYNC(psync), .PRBS_BIT_ERROR(perr),
    .REG_ADDR(addr), .REG_RDATA(rdata), .RX_POS_DATA_OUT(rpos_out),
    .RX_NEGATIVE_DATA_PIN(rx_negative_data_pin_out),
    .PRBS_ERROR_PULSE_OUT(prbs_error_pulse_out), .INSERT_BIPOLAR_VIOLATION(insert_bipolar_violation), .INSERT_LOGIC_ERROR(insert_logic_error),
    .TX_POS_IN(txp_in), .TX_NEG_IN(txn_in), .TX_POS_OUT(txp_out), .TX_NEG_OUT(txn_out)
  );

  leci_line_model line (
    .clk(clk), .srst(srst), .tx_pos_in(txp_in), .tx_neg_in(txn_in),
    .tx_pos(txp_out), .tx_neg(txn_out), .rx_pos(rx_pos), .rx_neg(rx_neg)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mon_en) begin
      n_neg  <= n_neg + int'(rx_negative_data_pin_out === 1'b1);
      n_prbs <= n_prbs + int'(prbs_error_pulse_out === 1'b1);
      n_pos  <= n_pos + int'(rpos_out === 1'b1);
    end
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    @(posedge clk);
    #1 d = rdata;
  endtask : rd

  task automatic read_count(output logic [15:0] cnt);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(8'h11, hi);
    rd(8'h12, lo);
    cnt = {hi, lo};
  endtask : read_count

  // Trigger dropped again after each latch, so every latch sees a fresh rise
  task automatic latch(output logic [15:0] cnt);
    @(posedge clk);
    #1 trig = 1'b1;
    mon_en = 1'b0;
    read_count(cnt);
    @(posedge clk);
    #1 trig = 1'b0;
  endtask : latch

  // Reset between scenarios so polarity history never leaks across them
  task automatic restart(input logic [1:0] lc, input logic [2:0] s);
    @(posedge clk);
    #1 srst = 1'b1;
    {lstd, coff, sel, insert_bipolar_violation, insert_logic_error, tx_last} = {lc, s, 3'h0};
    nrz = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    {n_neg, n_prbs, n_pos, mon_en} = {32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 1'b1};
  endtask : restart

  task automatic tx_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      #1 tx_last = tx_last ^ (s[i] == "M");
      {txp_in, txn_in} = (s[i] == "M") ? {tx_last, !tx_last} : 2'h0;
    end
  endtask : tx_str

  task automatic run(input string n, input logic [1:0] lc, input logic [2:0] s,
                     input string p, input logic [15:0] ec, input logic [15:0] en);
    logic [15:0] cnt;
    restart(lc, s);
    line.send_str(p);
    for (int i = 0; i < 4 && s[2]; i++) begin
      @(posedge clk);
      #1 {psync, perr} = {i != 3, 1'b1};
      @(posedge clk);
      #1 perr = 1'b0;
    end
    latch(cnt);
    check({n, " count"}, ec, cnt);
    check({n, " neg pin pulses"}, en, 16'(n_neg));
    check({n, " prbs pulses"}, s[2] ? 16'h0003 : 16'h0000, 16'(n_prbs));
    $display("done %s", n);
  endtask : run

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    {srst, lstd, coff, sel, trig, psync, perr, insert_bipolar_violation, insert_logic_error} = {1'b1, 10'h000};
    {addr, txp_in, txn_in, tx_last, mon_en, n_mismatch, comparisons} = 76'h0;
    nrz = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    read_count(v);
    check("reset count", 16'h0000, v);
    rd(8'h13, b);
    check("unmapped read", 16'h0000, {8'h00, b});
    run("e1 cv", 2'h0, 3'h0, PA, 16'h0001, 16'h0001);
    run("e1 bpv", 2'h0, 3'h1, PA, 16'h0002, 16'h0002);
    run("e1 cv exz", 2'h0, 3'h2, PA, 16'h0002, 16'h0002);
    run("e1 bpv exz", 2'h0, 3'h3, PA, 16'h0003, 16'h0003);
    run("hdb3 codeword", 2'h0, 3'h3, "M000V00", 16'h0000, 16'h0000);
    run("e1 ami bpv", 2'h1, 3'h3, "M000V00", 16'h0001, 16'h0001);
    run("t1 ami bpv", 2'h3, 3'h2, PB, 16'h0001, 16'h0001);
    run("t1 ami ten zeros", 2'h3, 3'h1, PB, 16'h0001, 16'h0001);
    run("t1 b8zs bpv", 2'h2, 3'h2, PB, 16'h0001, 16'h0001);
    run("t1 b8zs exz", 2'h2, 3'h1, PB, 16'h0002, 16'h0002);
    run("t1 ami exz", 2'h3, 3'h1, "M0000000000000000M00", 16'h0001, 16'h0001);
    run("prbs only", 2'h0, 3'h4, PA, 16'h0003, 16'h0001);
    // Bipolar output: pins mirror the line, errors still counted
    restart(2'h1, 3'h1);
    nrz = 1'b0;
    line.send_str("MM0V00");
    latch(v);
    check("bipolar count", 16'h0001, v);
    check("bipolar neg pin", 16'h0002, 16'(n_neg));
    check("bipolar pos pin", 16'h0001, 16'(n_pos));
    restart(2'h3, 3'h1);
    line.send_str("M");
    repeat (19) line.send_str("V");
    line.send_str("00");
    latch(v);
    check("one per cycle", 16'h0013, v);
    @(posedge clk);
    #1 trig = 1'b1;
    line.send_str("VVVVV00");
    read_count(v);
    check("held trigger", 16'h0000, v);
    @(posedge clk);
    #1 trig = 1'b0;
    latch(v);
    check("cleared count", 16'h0005, v);
    repeat (65540) line.send_str("V");
    line.send_str("00");
    latch(v);
    check("saturated count", 16'hFFFF, v);
    $display("done counter limits");
    restart(2'h0, 3'h0);
    @(posedge clk);
    #1 insert_logic_error = 1'b1;
    tx_str("0000000000");
    check("logic error bits", 16'h0001, 16'(line.tx_diffs));
    insert_logic_error = 1'b0;
    tx_str("00");
    insert_logic_error = 1'b1;
    tx_str("0000");
    check("logic error rearm", 16'h0002, 16'(line.tx_diffs));
    restart(2'h0, 3'h0);
    @(posedge clk);
    #1 insert_bipolar_violation = 1'b1;
    tx_str("MM0MM0MM0MM000");
    check("no three ones", 16'h0000, 16'(line.tx_diffs));
    tx_str("MMMMMMMMM00");
    check("violation bits", 16'h0001, 16'(line.tx_diffs));
    check("violation seen", 16'h0001, 16'(line.tx_viols > 0));
    insert_bipolar_violation = 1'b0;
    tx_str("00");
    insert_bipolar_violation = 1'b1;
    tx_str("MMM00");
    check("violation rearm", 16'h0002, 16'(line.tx_diffs));
    $display("done injection");
    tally_and_finish();
  end

  initial begin
    #(100000 * 50);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : leci_top_test
